//--- sfsr_defines.svh
`ifndef SFSR_DEFINES_SVH
`define SFSR_DEFINES_SVH
`define SFSR_OP_READ_STATUS 8'h05
`define SFSR_OP_WRITE_STATUS 8'h01
`define SFSR_OP_WRITE_STATUS2 8'h31
`define SFSR_OP_WRITE_ENABLE 8'h06
`define SFSR_OP_WRITE_DISABLE 8'h04
`define SFSR_OP_BYTE_PROGRAM 8'h02
`define SFSR_OP_SEC_PROGRAM 8'h9b
`define SFSR_OP_PAGE_ERASE 8'h81
`define SFSR_OP_BLOCK_ERASE_4K 8'h20
`define SFSR_OP_BLOCK_ERASE_32K 8'h52
`define SFSR_OP_CHIP_ERASE 8'h60
`define SFSR_OP_CHIP_ERASE_ALT 8'hc7
`define SFSR_BIT_BLOCK_LOCK 7
`define SFSR_BIT_PROGRAM_ERROR 5
`define SFSR_BIT_PIN_LEVEL 4
`define SFSR_BIT_ARRAY_PROTECT 2
`define SFSR_BIT_WEL 1
`define SFSR_BIT_BUSY 0
`define SFSR_BIT_RESET_EN 4
`define SFSR_RST_BLOCK_LOCK 1'b0
`define SFSR_RST_ARRAY_PROTECT 1'b0
`define SFSR_RST_WEL 1'b0
`define SFSR_RST_RESET_EN 1'b0
`define SFSR_RST_PROGRAM_ERROR 1'b0
`define SFSR_BITS_PER_BYTE 4'h8
`endif

//--- sfsr_host_model.sv
`timescale 1ns/1ps
module sfsr_host_model (
  // Serial link driven by the host.
  output logic sck,
  output logic cs_n,
  output logic si,
  // Serial link driven by the device.
  input wire logic so,
  input wire logic so_oe
);
  logic [63:0] rx_q;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
    rx_q = '0;
  end
  // opcode then data.
  // Mode 0 host: the clock stands low between frames, so the device sees no edges there.
  task automatic xfer(input logic [15:0] tx, input int ntx, input int nrx);
    cs_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      si = (i < ntx) ? tx[ntx-1-i] : ~si;
      #6 sck = 1'b1;
      // rising edge capture.
      // A released output floats to its pull-up level.
      rx_q = {rx_q[62:0], so_oe ? so : 1'b1};
      #6 sck = 1'b0;
    end
    #6 cs_n = 1'b1;
    si = 1'b1;
  endtask
endmodule

//--- sfsr_pkg.sv
package sfsr_pkg;
  typedef enum logic [1:0] {
    SFSR_CMD_NONE,
    SFSR_CMD_WRSR,
    SFSR_CMD_WRSR2,
    SFSR_CMD_OTHER
  } sfsr_cmd_e;
  typedef struct packed {
    logic done;
    logic failed;
    logic aborted;
  } sfsr_op_s;
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] data;
    logic full_byte;
  } sfsr_frame_s;
endpackage

//--- sfsr_status.sv
`timescale 1ns/1ps
`include "sfsr_defines.svh"
// Contract
// - Status read accepted any time, even busy.
// - Opcode 05h then one bit per clock.
// - Byte1 msb-first, byte2, then repeat.
// - Each repetition carries fresh status.
// - Chip select high ends read, output released.
// - Both status bytes always streamed.
// - Byte1 bits 6 and 3 read zero.
// - Write status changes only bits 7,2.
// - Lock plus pin asserted freezes protect.
// - Lock zero unlocks protect; lock resets zero.
// - Pin asserted: lock only set, never cleared.
// - Program error reflects last operation failure.
// - Aborted operations never set program error.
// - Program error updated after every non-aborted operation.
// - Pin level bit zero when pin asserted.
// - Protect bit blocks all program, erase.
// - Write enable latch readable, read-only.
// - Latch clear rejects writes and erases.
// - Latch zero after power-up and reset.
// - Latch cleared on completion or abort.
// - Incomplete opcode abort keeps latch set.
// - Busy bit shows internal operation running.
// - Byte2: reset enable bit4, busy bit0.
// - Write status 01h plus one byte.
module sfsr_status (
  // System side.
  input wire logic clk,
  input wire logic rst,
  // Serial link; the serial clock is the link domain.
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Write-protect pin, active low.
  input wire logic wp_n,
  // Array engine.
  input wire logic op_busy,
  input wire sfsr_pkg::sfsr_op_s op_result,
  output logic write_allowed,
  output logic array_locked,
  // Status view.
  output logic [7:0] status_byte_one,
  output logic [7:0] status_byte_two
);
  import sfsr_pkg::*;

  // Link domain: opcode and data capture on rising sck.
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] opcode_q;
  logic [7:0] data_q;
  logic op_seen_q;
  logic data_seen_q;
  logic reading_q;
  logic [3:0] out_idx_q;
  logic [15:0] snap_q;
  logic so_q;

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      op_seen_q <= 1'b0;
      data_seen_q <= 1'b0;
    end else begin
      shift_q <= {shift_q[6:0], si};
      if (bit_cnt_q == `SFSR_BITS_PER_BYTE - 4'h1) begin
        bit_cnt_q <= 4'h0;
        if (!op_seen_q) begin
          op_seen_q <= 1'b1;
        end else begin
          data_seen_q <= 1'b1;
        end
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  // The cs_n reset wipes the counters the moment a frame ends, before the
  // system side can look at them. These copies follow every rising sck and
  // are never reset, so they still describe the last frame afterwards.
  // Limitation: a frame without a single sck edge leaves the summary of the
  // frame before it in place, and that command is then seen a second time.
  logic frame_op_q;
  logic frame_data_q;
  logic frame_aligned_q;
  wire byte_last = bit_cnt_q == `SFSR_BITS_PER_BYTE - 4'h1;

  always_ff @(posedge sck) begin
    frame_op_q <= op_seen_q || byte_last;
    frame_data_q <= data_seen_q || (op_seen_q && byte_last);
    frame_aligned_q <= byte_last;
  end

  // Opcode and data keep their value past the frame for the system side.
  always_ff @(posedge sck) begin
    if (!cs_n && bit_cnt_q == `SFSR_BITS_PER_BYTE - 4'h1) begin
      if (!op_seen_q) begin
        opcode_q <= {shift_q[6:0], si};
      end else if (!data_seen_q) begin
        data_q <= {shift_q[6:0], si};
      end
    end
  end

  // Status snapshot from the system side, resynchronised into sck.
  logic [15:0] status_sync1_q;
  logic [15:0] status_sync2_q;
  always_ff @(posedge sck) begin
    status_sync1_q <= {status_byte_one, status_byte_two};
    status_sync2_q <= status_sync1_q;
  end

  // falling-edge shifter. stream both bytes forever.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      reading_q <= 1'b0;
      out_idx_q <= 4'h0;
      snap_q <= 16'h0000;
      so_q <= 1'b0;
    end else if (reading_q) begin
      out_idx_q <= out_idx_q + 4'h1;
      if (out_idx_q == 4'hf) begin
        snap_q <= status_sync2_q;
        so_q <= status_sync2_q[15];
      end else begin
        so_q <= snap_q[4'hf - (out_idx_q + 4'h1)];
      end
    end else if (op_seen_q && opcode_q == `SFSR_OP_READ_STATUS) begin
      reading_q <= 1'b1;
      out_idx_q <= 4'h0;
      snap_q <= status_sync2_q;
      so_q <= status_sync2_q[15];
    end
  end

  // drive only while a read is in progress.
  assign so = so_q;
  assign so_oe = reading_q;

  // System domain: detect frame end.
  logic cs_sync1_q, cs_sync2_q, cs_prev_q;
  logic wp_sync1_q, wp_sync2_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_sync1_q <= 1'b1;
      cs_sync2_q <= 1'b1;
      cs_prev_q <= 1'b1;
      wp_sync1_q <= 1'b1;
      wp_sync2_q <= 1'b1;
    end else begin
      cs_sync1_q <= cs_n;
      cs_sync2_q <= cs_sync1_q;
      cs_prev_q <= cs_sync2_q;
      wp_sync1_q <= wp_n;
      wp_sync2_q <= wp_sync1_q;
    end
  end
  wire frame_end = cs_sync2_q && !cs_prev_q;
  wire pin_asserted = !wp_sync2_q;

  // Frame fields are stable after cs_n rises; two synchronised clk cycles cover them.
  sfsr_frame_s frame;
  always_comb begin
    frame.valid = frame_end && frame_op_q;
    frame.opcode = opcode_q;
    frame.data = data_q;
    frame.full_byte = frame_data_q && frame_aligned_q;
  end

  logic block_lock_q, array_protect_q, wel_q, reset_en_q, prog_err_q;
  wire is_wrsr = frame.opcode == `SFSR_OP_WRITE_STATUS;
  wire is_wrsr2 = frame.opcode == `SFSR_OP_WRITE_STATUS2;
  wire is_array_cmd = frame.opcode == `SFSR_OP_BYTE_PROGRAM ||
    frame.opcode == `SFSR_OP_SEC_PROGRAM ||
    frame.opcode == `SFSR_OP_PAGE_ERASE ||
    frame.opcode == `SFSR_OP_BLOCK_ERASE_4K ||
    frame.opcode == `SFSR_OP_BLOCK_ERASE_32K ||
    frame.opcode == `SFSR_OP_CHIP_ERASE ||
    frame.opcode == `SFSR_OP_CHIP_ERASE_ALT;
  wire new_lock = frame.data[`SFSR_BIT_BLOCK_LOCK];
  wire lock_clear_refused = pin_asserted && block_lock_q && !new_lock;
  wire wrsr_ok = frame.valid && is_wrsr && wel_q && frame.full_byte && !op_busy;

  always_ff @(posedge clk) begin
    if (rst) begin
      block_lock_q <= `SFSR_RST_BLOCK_LOCK;
      array_protect_q <= `SFSR_RST_ARRAY_PROTECT;
    end else if (wrsr_ok && !lock_clear_refused) begin
      block_lock_q <= new_lock;
      if (!(block_lock_q && pin_asserted)) begin
        array_protect_q <= frame.data[`SFSR_BIT_ARRAY_PROTECT];
      end
    end
  end

  // reset enable written only by the byte-two command.
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_en_q <= `SFSR_RST_RESET_EN;
    end else if (frame.valid && is_wrsr2 && wel_q && frame.full_byte && !op_busy) begin
      reset_en_q <= frame.data[`SFSR_BIT_RESET_EN];
    end
  end

  // latch set, auto-clear after any full write-class opcode.
  always_ff @(posedge clk) begin
    if (rst) begin
      wel_q <= `SFSR_RST_WEL;
    end else if (frame.valid && frame.opcode == `SFSR_OP_WRITE_ENABLE && !op_busy) begin
      wel_q <= 1'b1;
    end else if (frame.valid && (frame.opcode == `SFSR_OP_WRITE_DISABLE ||
                 is_wrsr || is_wrsr2 || is_array_cmd)) begin
      wel_q <= 1'b0;
    end else if (op_result.done || op_result.aborted) begin
      wel_q <= 1'b0;
    end
  end

  // error reflects last finished operation; aborts leave it.
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_err_q <= `SFSR_RST_PROGRAM_ERROR;
    end else if (op_result.done && !op_result.aborted) begin
      prog_err_q <= op_result.failed;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      write_allowed <= 1'b0;
      array_locked <= 1'b0;
    end else begin
      write_allowed <= wel_q;
      array_locked <= array_protect_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_byte_one <= 8'h10;
      status_byte_two <= 8'h00;
    end else begin
      status_byte_one <= {block_lock_q, 1'b0, prog_err_q, !pin_asserted,
                          1'b0, array_protect_q, wel_q, op_busy};
      status_byte_two <= {3'h0, reset_en_q, 3'h0, op_busy};
    end
  end

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    status_byte_one[6] == 1'b0 && status_byte_one[3] == 1'b0)
    else $error("reserved status bit set");
  a_busy_mirror: assert property (@(posedge clk) disable iff (rst)
    status_byte_one[0] == $past(op_busy))
    else $error("busy bit wrong");
  a_busy_both: assert property (@(posedge clk) disable iff (rst)
    status_byte_one[0] == status_byte_two[0])
    else $error("busy bytes disagree");
  a_pin_level: assert property (@(posedge clk) disable iff (rst)
    status_byte_one[4] == $past(wp_sync2_q))
    else $error("pin level bit wrong");
  a_lock_no_clear: assert property (@(posedge clk) disable iff (rst)
    (block_lock_q && pin_asserted) |=> block_lock_q)
    else $error("lock cleared while pin asserted");
  a_protect_frozen: assert property (@(posedge clk) disable iff (rst)
    (block_lock_q && pin_asserted) |=> $stable(array_protect_q))
    else $error("protect changed while frozen");
  a_wel_clear: assert property (@(posedge clk) disable iff (rst)
    (frame.valid && is_wrsr) |=> !wel_q)
    else $error("latch not cleared after write status");
  a_abort_err: assert property (@(posedge clk) disable iff (rst)
    (op_result.aborted) |=> $stable(prog_err_q))
    else $error("error changed on abort");
  a_err_update: assert property (@(posedge clk) disable iff (rst)
    (op_result.done && !op_result.aborted) |=> prog_err_q == $past(op_result.failed))
    else $error("error not updated");
  a_wrsr_noen: assert property (@(posedge clk) disable iff (rst)
    (frame.valid && is_wrsr && !wel_q) |=> $stable(block_lock_q))
    else $error("write status accepted without latch");

  // Reset values hold even though the checks above are disabled in reset.
  a_wel_reset: assert property (@(posedge clk)
    rst |=> !wel_q)
    else $error("latch set after reset");

  a_lock_reset: assert property (@(posedge clk)
    rst |=> !block_lock_q)
    else $error("lock set after reset");

  a_reset_cmd_enable_reset: assert property (@(posedge clk)
    rst |=> !reset_en_q)
    else $error("reset enable set after reset");

  a_wel_set: assert property (@(posedge clk) disable iff (rst)
    (frame.valid && frame.opcode == `SFSR_OP_WRITE_ENABLE && !op_busy) |=> wel_q)
    else $error("latch not set by write enable");

  a_wel_disable: assert property (@(posedge clk) disable iff (rst)
    (frame.valid && frame.opcode == `SFSR_OP_WRITE_DISABLE) |=> !wel_q)
    else $error("latch not cleared by write disable");

  a_done_wel: assert property (@(posedge clk) disable iff (rst)
    (op_result.done && !(frame.valid && frame.opcode == `SFSR_OP_WRITE_ENABLE))
    |=> !wel_q)
    else $error("latch not cleared after operation");

  a_short_keep: assert property (@(posedge clk) disable iff (rst)
    (frame_end && !frame_op_q && !op_result.done && !op_result.aborted)
    |=> $stable(wel_q))
    else $error("latch changed by short opcode");

  a_allowed_copy: assert property (@(posedge clk) disable iff (rst)
    write_allowed == $past(wel_q))
    else $error("write gate disagrees with latch");

  a_locked_copy: assert property (@(posedge clk) disable iff (rst)
    array_locked == $past(array_protect_q))
    else $error("array gate disagrees with protect bit");

  a_byte2_zero: assert property (@(posedge clk) disable iff (rst)
    status_byte_two[7:5] == 3'h0 && status_byte_two[3:1] == 3'h0)
    else $error("reserved byte two bit set");

  a_lock_shown: assert property (@(posedge clk) disable iff (rst)
    status_byte_one[7] == $past(block_lock_q))
    else $error("lock bit not shown");

  a_partial_wrsr: assert property (@(posedge clk) disable iff (rst)
    (frame.valid && is_wrsr && !frame.full_byte)
    |=> $stable(block_lock_q) && $stable(array_protect_q) && !wel_q)
    else $error("partial write status took effect");

  a_busy_wrsr: assert property (@(posedge clk) disable iff (rst)
    (frame.valid && is_wrsr && op_busy)
    |=> $stable(block_lock_q) && $stable(array_protect_q))
    else $error("write status taken while busy");

  a_reset_cmd_enable_hold: assert property (@(posedge clk) disable iff (rst)
    !(frame.valid && is_wrsr2) |=> $stable(reset_en_q))
    else $error("reset enable changed without command");

  a_err_hold: assert property (@(posedge clk) disable iff (rst)
    !op_result.done |=> $stable(prog_err_q))
    else $error("error changed without operation");

  a_protect_free: assert property (@(posedge clk) disable iff (rst)
    (wrsr_ok && !lock_clear_refused && !(block_lock_q && pin_asserted))
    |=> array_protect_q == $past(frame.data[`SFSR_BIT_ARRAY_PROTECT]))
    else $error("unlocked protect not written");

  // The output enable drops with cs_n itself, long before the synchronised
  // copy has seen the frame end twice.
  a_oe_idle: assert property (@(posedge clk) disable iff (rst)
    (cs_sync2_q && cs_prev_q) |-> !so_oe)
    else $error("serial output driven outside a frame");

  c_wrsr: cover property (@(posedge clk) disable iff (rst) wrsr_ok);
  c_partial: cover property (@(posedge clk) disable iff (rst)
    frame.valid && is_wrsr && !frame.full_byte);
  c_busy_fall: cover property (@(posedge clk) disable iff (rst) $fell(status_byte_one[0]));
  c_lock_set: cover property (@(posedge clk) disable iff (rst) $rose(block_lock_q));
  c_read: cover property (@(posedge clk) disable iff (rst) !cs_sync2_q && reading_q);
endmodule

//--- tb_spi_flash_status_register.sv
`timescale 1ns/1ps
module tb_spi_flash_status_register;
  import sfsr_pkg::*;
  logic clk, rst, wp_n, op_busy, sck, cs_n, si, so, so_oe, write_allowed, array_locked;
  sfsr_op_s op_result;
  logic [7:0] status_byte_one, status_byte_two;
  logic [15:0] e;
  int err_total = 0;
  int total_checks = 0;
  int seed = 11426;
  int lock = 0, prot = 0, err = 0, write_enable_latch = 0, reset_cmd_enable = 0;
  sfsr_status dut_u (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .wp_n(wp_n), .op_busy(op_busy), .op_result(op_result),
    .write_allowed(write_allowed), .array_locked(array_locked),
    .status_byte_one(status_byte_one), .status_byte_two(status_byte_two));
  sfsr_host_model host_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] two(input int busy);
    return {lock[0], 1'b0, err[0], wp_n, 1'b0, prot[0], write_enable_latch[0], busy[0],
            3'h0, reset_cmd_enable[0], 3'h0, busy[0]};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmd(input logic [15:0] tx, input int ntx);
    host_u.xfer(tx, ntx, 0);
    idle(10);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge clk) op_result <= sfsr_op_s'(v);
    @(posedge clk) op_result <= '0;
    idle(6);
  endtask
  // Two full repetitions on the wire and the same view at the ports.
  task automatic rd(input string name);
    host_u.xfer(16'h0005, 8, 32);
    idle(4);
    check(host_u.rx_q[31:16], two(0));
    check(host_u.rx_q[15:0], two(0));
    check({status_byte_one, status_byte_two}, two(0));
    check({13'h0, so_oe, write_allowed, array_locked}, {13'h0, 1'b0, write_enable_latch[0], prot[0]});
    $display("test %s done", name);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    idle(40000);
    err_total++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    op_busy = 1'b0;
    op_result = '0;
    idle(12);
    rst <= 1'b0;
    idle(10);
    rd("reset");
    cmd(16'h0006, 8);
    write_enable_latch = 1;
    rd("latch");
    // only two bits change; the ignored bits carry random values.
    cmd({8'h01, 8'h84 | (8'($random(seed)) & 8'h7b)}, 16);
    lock = 1;
    prot = 1;
    write_enable_latch = 0;
    rd("write");
    @(posedge clk) wp_n <= 1'b0;
    idle(6);
    rd("pin");
    cmd(16'h0006, 8);
    cmd(16'h0100, 16);
    rd("lockclear");
    cmd(16'h0006, 8);
    cmd(16'h0180, 16);
    rd("frozen");
    @(posedge clk) wp_n <= 1'b1;
    idle(6);
    cmd(16'h0006, 8);
    cmd(16'h0100, 16);
    lock = 0;
    prot = 0;
    rd("unlock");
    cmd(16'h0184, 16);
    rd("nolatch");
    cmd(16'h0006, 8);
    cmd(16'h0000, 4);
    write_enable_latch = 1;
    rd("shortop");
    cmd(16'h0018, 12);
    write_enable_latch = 0;
    rd("partial");
    cmd(16'h0006, 8);
    pulse(3'b110);
    err = 1;
    rd("fail");
    pulse(3'b111);
    rd("abort");
    pulse(3'b100);
    err = 0;
    rd("success");
    // byte-two write sets the reset enable.
    cmd(16'h0006, 8);
    cmd(16'h3110, 16);
    reset_cmd_enable = 1;
    rd("resetenable");
    host_u.xfer(16'h0005, 8, 5);
    idle(4);
    e = two(0);
    check(16'(host_u.rx_q[4:0]), 16'(e[15:11]));
    check(16'(so_oe), 16'h0000);
    $display("test partialread done");
    @(posedge clk) op_busy <= 1'b1;
    idle(6);
    fork
      host_u.xfer(16'h0005, 8, 64);
      begin
        idle(30);
        op_busy <= 1'b0;
      end
    join
    idle(4);
    check(host_u.rx_q[63:48], two(1));
    check(host_u.rx_q[15:0], two(0));
    $display("test busy done");
    report_and_stop();
  end
endmodule
